// >>> rtl/edoc_pkg.sv
// constants for the host-side controller of a 256K x 16 page-mode dram
// assumes one 250 MHz clock; all dram pins are asynchronous to it
// What this block does
// - wait 200 us, then eight refresh wake-ups
// - pulse both strobes high between cycles
// - read keeps write strobe high past strobes
// - output enable high, late write strobe: late write
// - output enable tied low: early writes only
// - write command is write strobe falling
// - output enable high around late writes
// - row-only refresh refreshes addressed row
// - hidden refresh after read: write high, oe low (not done: refresh only from idle)
// - hidden refresh after write: write low, oe high (not done: refresh only from idle)
// - 512 refreshes every 8 ms
package edoc_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned WAKE_US = 200;
  localparam int unsigned WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam int unsigned WAKE_REFRESHES = 8;
  localparam int unsigned REF_PERIOD_MS = 8;
  localparam int unsigned REF_ROWS = 512;
  // longest interval: round down
  localparam int unsigned REF_INT_CYC = (REF_PERIOD_MS * 1000 * CLK_MHZ) / REF_ROWS;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 16;
  // phase lengths in cycles, each at least the printed minimum (4 ns per cycle)
  localparam int unsigned T_RAS_NS = 35;
  localparam int unsigned T_RP_NS = 25;
  localparam int unsigned T_RCD_NS = 13;
  localparam int unsigned T_CAS_NS = 13;
  localparam int unsigned T_CSR_NS = 8;
  localparam int unsigned T_OEH_NS = 8;
  localparam int unsigned T_RAS_CYC = (T_RAS_NS + 3) / 4;
  localparam int unsigned T_RP_CYC = (T_RP_NS + 3) / 4;
  localparam int unsigned T_RCD_CYC = (T_RCD_NS + 3) / 4;
  localparam int unsigned T_CAS_CYC = (T_CAS_NS + 3) / 4 + 1;
  localparam int unsigned T_CSR_CYC = (T_CSR_NS + 3) / 4;
  localparam int unsigned T_OEH_CYC = (T_OEH_NS + 3) / 4;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_EARLY_WRITE = 2'h1;
  localparam logic [1:0] OP_LATE_WRITE = 2'h2;
  localparam logic [1:0] OP_RMW = 2'h3;
  typedef enum logic [3:0] {
    ST_WAKE = 4'h0,
    ST_IDLE = 4'h1,
    ST_ROW = 4'h2,
    ST_COL = 4'h3,
    ST_WRITE = 4'h4,
    ST_OEOFF = 4'h5,
    ST_PRE = 4'h6,
    ST_REF_CAS = 4'h7,
    ST_REF_RAS = 4'h8
  } edoc_state_t;
endpackage

// >>> rtl/edoc_sync.sv
// two-flop synchroniser for the data pins read back from the dram
// assumes the pins are asynchronous to clk_i
`timescale 1ns/100ps
module edoc_sync #(
  parameter int unsigned W = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule

// >>> rtl/edoc_ctrl.sv
// host controller: sequences strobes for reads, writes and refresh of the dram
// assumes a single request port on clk_i; dram pins asynchronous
`timescale 1ns/100ps
module edoc_ctrl #(
  parameter int unsigned WAKE_CYC = edoc_pkg::WAKE_CYC,
  parameter int unsigned REF_INT_CYC = edoc_pkg::REF_INT_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [1:0] req_op_i,
  input wire logic [17:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic [1:0] req_be_i,
  input wire logic [15:0] req_mdata_i,
  output logic rsp_valid_o,
  output logic [15:0] rsp_rdata_o,
  output logic init_done_o,
  output logic row_strobe_n_o,
  output logic lower_column_strobe_n_o,
  output logic upper_column_strobe_n_o,
  output logic write_strobe_n_o,
  output logic output_enable_n_o,
  output logic [8:0] mux_address_pins_o,
  input wire logic [15:0] data_pins_i,
  output logic [15:0] data_pins_o,
  output logic data_pins_oe_o
);
  edoc_pkg::edoc_state_t st_q;
  logic [17:0] cnt_q;
  logic [17:0] ref_cnt_q;
  logic ref_due_q;
  logic [3:0] wake_left_q;
  logic [1:0] op_q;
  logic [17:0] addr_q;
  logic [15:0] wdata_q;
  logic [1:0] be_q;
  logic [15:0] mdata_q;
  logic [15:0] pins_sync;
  logic is_write;

  edoc_sync #(
    .W(edoc_pkg::DATA_W)
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(data_pins_i),
    .sync_o(pins_sync)
  );

  function automatic logic [17:0] cyc(input int unsigned n);
    cyc = 18'(n - 1);
  endfunction

  assign is_write = (op_q != edoc_pkg::OP_READ);
  assign req_ready_o = (st_q == edoc_pkg::ST_IDLE) && !ref_due_q;

  // refresh interval timer, 512 rows every 8 ms
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ref_cnt_q <= 18'h0;
      ref_due_q <= 1'b0;
    end else if (ref_cnt_q >= cyc(REF_INT_CYC)) begin
      ref_cnt_q <= 18'h0;
      ref_due_q <= 1'b1;
    end else begin
      ref_cnt_q <= ref_cnt_q + 18'h1;
      if (st_q == edoc_pkg::ST_REF_RAS && cnt_q == 18'h0)
        ref_due_q <= 1'b0;
    end
  end

  // main sequencer; strobes held as flops so no glitches reach the pins
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_q <= edoc_pkg::ST_WAKE;
      cnt_q <= 18'h0;
      wake_left_q <= 4'h0;
      init_done_o <= 1'b0;
      op_q <= 2'h0;
      addr_q <= 18'h0;
      wdata_q <= 16'h0;
      be_q <= 2'h0;
      mdata_q <= 16'h0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 16'h0;
      row_strobe_n_o <= 1'b1;
      lower_column_strobe_n_o <= 1'b1;
      upper_column_strobe_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      output_enable_n_o <= 1'b1;
      mux_address_pins_o <= 9'h0;
      data_pins_o <= 16'h0;
      data_pins_oe_o <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      case (st_q)
        edoc_pkg::ST_WAKE: begin
          // power-up pause then eight refreshes
          if (cnt_q >= cyc(WAKE_CYC)) begin
            cnt_q <= 18'h0;
            wake_left_q <= 4'(edoc_pkg::WAKE_REFRESHES);
            st_q <= edoc_pkg::ST_PRE;
          end else begin
            cnt_q <= cnt_q + 18'h1;
          end
        end
        edoc_pkg::ST_IDLE: begin
          if (ref_due_q) begin
            // refresh only from idle, never hidden behind an access: write strobe and oe park high
            // strobe-order refresh: column strobes fall first, write held high
            lower_column_strobe_n_o <= 1'b0;
            upper_column_strobe_n_o <= 1'b0;
            write_strobe_n_o <= 1'b1;
            output_enable_n_o <= 1'b1;
            cnt_q <= cyc(edoc_pkg::T_CSR_CYC);
            st_q <= edoc_pkg::ST_REF_CAS;
          end else if (req_valid_i) begin
            op_q <= req_op_i;
            addr_q <= req_addr_i;
            wdata_q <= req_wdata_i;
            be_q <= req_be_i;
            mdata_q <= req_mdata_i;
            // row latched on row strobe fall
            mux_address_pins_o <= req_addr_i[17:9];
            row_strobe_n_o <= 1'b0;
            // early write: write strobe falls before column strobe
            write_strobe_n_o <= (req_op_i != edoc_pkg::OP_EARLY_WRITE);
            if (req_op_i == edoc_pkg::OP_EARLY_WRITE) begin
              data_pins_o <= req_wdata_i;
              data_pins_oe_o <= 1'b1;
            end
            // read and rmw drive oe low; late write keeps it high
            output_enable_n_o <= (req_op_i == edoc_pkg::OP_EARLY_WRITE) || (req_op_i == edoc_pkg::OP_LATE_WRITE);
            cnt_q <= cyc(edoc_pkg::T_RCD_CYC);
            st_q <= edoc_pkg::ST_ROW;
          end
        end
        edoc_pkg::ST_ROW: begin
          if (cnt_q == 18'h0) begin
            mux_address_pins_o <= addr_q[8:0];
            // byte lanes: lower strobe bits 7:0, upper 15:8
            lower_column_strobe_n_o <= !(be_q[0] || !is_write);
            upper_column_strobe_n_o <= !(be_q[1] || !is_write);
            cnt_q <= cyc(edoc_pkg::T_CAS_CYC + 1);
            st_q <= edoc_pkg::ST_COL;
          end else begin
            cnt_q <= cnt_q - 18'h1;
          end
        end
        edoc_pkg::ST_COL: begin
          if (cnt_q == 18'h0) begin
            if (op_q == edoc_pkg::OP_LATE_WRITE || op_q == edoc_pkg::OP_RMW) begin
              if (op_q == edoc_pkg::OP_RMW)
                rsp_rdata_o <= pins_sync;
              // oe high before write data goes out
              output_enable_n_o <= 1'b1;
              cnt_q <= cyc(edoc_pkg::T_OEH_CYC);
              st_q <= edoc_pkg::ST_OEOFF;
            end else begin
              if (op_q == edoc_pkg::OP_READ) begin
                rsp_rdata_o <= pins_sync;
                rsp_valid_o <= 1'b1;
              end
              // read: write strobe stays high until strobes rise
              row_strobe_n_o <= 1'b1;
              lower_column_strobe_n_o <= 1'b1;
              upper_column_strobe_n_o <= 1'b1;
              output_enable_n_o <= 1'b1;
              write_strobe_n_o <= 1'b1;
              data_pins_oe_o <= 1'b0;
              cnt_q <= cyc(edoc_pkg::T_RP_CYC);
              st_q <= edoc_pkg::ST_PRE;
            end
          end else begin
            cnt_q <= cnt_q - 18'h1;
          end
        end
        edoc_pkg::ST_OEOFF: begin
          if (cnt_q == 18'h0) begin
            // late write: data taken at write strobe fall
            data_pins_o <= (op_q == edoc_pkg::OP_RMW) ? mdata_q : wdata_q;
            data_pins_oe_o <= 1'b1;
            write_strobe_n_o <= 1'b0;
            cnt_q <= cyc(edoc_pkg::T_CAS_CYC);
            st_q <= edoc_pkg::ST_WRITE;
          end else begin
            cnt_q <= cnt_q - 18'h1;
          end
        end
        edoc_pkg::ST_WRITE: begin
          if (cnt_q == 18'h0) begin
            if (op_q == edoc_pkg::OP_RMW)
              rsp_valid_o <= 1'b1;
            row_strobe_n_o <= 1'b1;
            lower_column_strobe_n_o <= 1'b1;
            upper_column_strobe_n_o <= 1'b1;
            write_strobe_n_o <= 1'b1;
            data_pins_oe_o <= 1'b0;
            cnt_q <= cyc(edoc_pkg::T_RP_CYC);
            st_q <= edoc_pkg::ST_PRE;
          end else begin
            cnt_q <= cnt_q - 18'h1;
          end
        end
        edoc_pkg::ST_REF_CAS: begin
          if (cnt_q == 18'h0) begin
            row_strobe_n_o <= 1'b0;
            cnt_q <= cyc(edoc_pkg::T_RAS_CYC);
            st_q <= edoc_pkg::ST_REF_RAS;
          end else begin
            cnt_q <= cnt_q - 18'h1;
          end
        end
        edoc_pkg::ST_REF_RAS: begin
          if (cnt_q == 18'h0) begin
            row_strobe_n_o <= 1'b1;
            lower_column_strobe_n_o <= 1'b1;
            upper_column_strobe_n_o <= 1'b1;
            cnt_q <= cyc(edoc_pkg::T_RP_CYC);
            st_q <= edoc_pkg::ST_PRE;
          end else begin
            cnt_q <= cnt_q - 18'h1;
          end
        end
        edoc_pkg::ST_PRE: begin
          // both strobes high for precharge before any new cycle
          if (cnt_q == 18'h0) begin
            if (wake_left_q != 4'h0) begin
              // wake-up walks rows 7 down to 0 with row-only refresh
              wake_left_q <= wake_left_q - 4'h1;
              mux_address_pins_o <= 9'(wake_left_q - 4'h1);
              row_strobe_n_o <= 1'b0;
              cnt_q <= cyc(edoc_pkg::T_RAS_CYC);
              st_q <= edoc_pkg::ST_REF_RAS;
            end else begin
              init_done_o <= 1'b1;
              st_q <= edoc_pkg::ST_IDLE;
            end
          end else begin
            cnt_q <= cnt_q - 18'h1;
          end
        end
        default: st_q <= edoc_pkg::ST_IDLE;
      endcase
    end
  end

  // no request is taken before the wake-up sequence is over
  wake_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    req_ready_o |-> init_done_o) else $error("ready before wake-up done");
  strobe_order_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(row_strobe_n_o) && st_q == edoc_pkg::ST_REF_RAS && init_done_o |-> write_strobe_n_o && !lower_column_strobe_n_o)
    else $error("refresh without column strobe first");
  row_only_ref_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(row_strobe_n_o) && st_q == edoc_pkg::ST_REF_RAS && !init_done_o |-> lower_column_strobe_n_o && upper_column_strobe_n_o)
    else $error("wake-up refresh with column strobe low");
  read_we_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !row_strobe_n_o && op_q == edoc_pkg::OP_READ && st_q != edoc_pkg::ST_REF_RAS |-> write_strobe_n_o)
    else $error("write strobe low in read");
  late_oe_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(write_strobe_n_o) && !row_strobe_n_o && !lower_column_strobe_n_o |-> output_enable_n_o)
    else $error("late write with oe low");
  drive_oe_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    data_pins_oe_o |-> output_enable_n_o) else $error("bus clash with memory");
  precharge_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(row_strobe_n_o) |=> row_strobe_n_o [*5]) else $error("precharge too short");
  ref_due_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ref_due_q && st_q == edoc_pkg::ST_IDLE |=> st_q == edoc_pkg::ST_REF_CAS)
    else $error("refresh not started");
  early_we_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_q == edoc_pkg::ST_ROW && op_q == edoc_pkg::OP_EARLY_WRITE |-> !write_strobe_n_o && data_pins_oe_o)
    else $error("early write strobe late");
endmodule

// >>> dv/edoc_dram_model.sv
// behavioural model of the 256K x 16 page-mode dram seen by edoc_ctrl
// assumes strobes straight from the controller; data pins have no pull
`timescale 1ns/100ps
module edoc_dram_model (
  input wire logic row_n_i,
  input wire logic [1:0] col_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [8:0] addr_i,
  input wire logic [15:0] ctrl_data_i,
  input wire logic ctrl_oe_i,
  output logic [15:0] pins_o,
  output int refresh_cnt_o,
  output int err_cnt_o
);
  logic [15:0] mem [0:262143];
  logic [8:0] row_q;
  logic [8:0] col_q [2];
  logic [1:0] valid_q = 2'h0;
  logic early_q = 1'b0;
  logic ras_only_q = 1'b0;
  real t_row = 0.0;
  real t_col = 0.0;
  // a late write strobe closer than these to the strobes is counted in err_cnt_o
  localparam real T_CWD_NS = 25.0;
  localparam real T_RWD_NS = 46.0;
  logic [1:0] drv;
  task automatic put(input int l);
    mem[{row_q, col_q[l]}][l*8 +: 8] = ctrl_data_i[l*8 +: 8];
  endtask
  initial begin
    refresh_cnt_o = 0;
    err_cnt_o = 0;
    pins_o = 16'h0;
    foreach (mem[i]) mem[i] = 16'h0;
  end
  always @(negedge row_n_i) begin
    if (col_n_i != 2'h3 && we_n_i) begin
      ras_only_q = 1'b0;
      refresh_cnt_o++;
    end else begin
      ras_only_q = 1'b1;
      t_row = $realtime;
      row_q = addr_i;
    end
  end
  // a row cycle that saw no column strobe was a row-only refresh
  always @(posedge row_n_i) begin
    if (ras_only_q) refresh_cnt_o++;
    ras_only_q = 1'b0;
  end
  for (genvar l = 0; l < 2; l++) begin : g_lane
    always @(negedge col_n_i[l]) begin
      if (!row_n_i) begin
        col_q[l] = addr_i;
        ras_only_q = 1'b0;
        t_col = $realtime;
        valid_q[l] = 1'b1;
        if (refresh_cnt_o < 8) err_cnt_o++;
        early_q = !we_n_i;
        #1;
        if (early_q) put(l);
      end
    end
    always @(posedge row_n_i or posedge col_n_i[l]) begin
      if (row_n_i && col_n_i[l]) valid_q[l] = 1'b0;
    end
  end
  always @(negedge we_n_i) begin
    if (!row_n_i && col_n_i != 2'h3 && !early_q) begin
      if (!oe_n_i) err_cnt_o++;
      if ($realtime - t_col < T_CWD_NS || $realtime - t_row < T_RWD_NS) err_cnt_o++;
      #1;
      for (int l = 0; l < 2; l++) begin
        if (!col_n_i[l]) put(l);
      end
    end
  end
  // evaluated off the clock edges; an undriven lane toggles so no stale value passes
  initial begin
    #0.5;
    forever begin
      #1;
      for (int l = 0; l < 2; l++) begin
        drv[l] = valid_q[l] && !oe_n_i && we_n_i && !early_q;
        if (drv[l] && ctrl_oe_i) err_cnt_o++;
        pins_o[l*8 +: 8] = drv[l] ? mem[{row_q, col_q[l]}][l*8 +: 8] :
                           ctrl_oe_i ? ctrl_data_i[l*8 +: 8] : ~pins_o[l*8 +: 8];
      end
    end
  end
endmodule

// >>> dv/edoc_ctrl_tb.sv
// self-checking bench for edoc_ctrl against the dram model
// assumes short wake-up and refresh interval parameters
`timescale 1ns/100ps
module edoc_ctrl_tb;
  localparam int unsigned WAKE = 20;
  localparam int unsigned REF_INT = 200;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic [1:0] req_op_i = 2'h0;
  logic [1:0] rop = 2'h0;
  logic [17:0] req_addr_i = 18'h0;
  logic [15:0] req_wdata_i = 16'h0;
  logic [1:0] req_be_i = 2'h3;
  logic [15:0] req_mdata_i = 16'h0;
  logic req_ready_o, rsp_valid_o, init_done_o, row_n, lcol_n, ucol_n, we_n, oe_n, doe;
  logic [15:0] rsp_rdata_o, pins, dout;
  logic [8:0] addr;
  int refresh_cnt, model_err, t_init, n;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [15:0] ref_mem [int];
  logic [17:0] pool [8];
  edoc_ctrl #(.WAKE_CYC(WAKE), .REF_INT_CYC(REF_INT)) edoc_ctrl_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_op_i(req_op_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_be_i(req_be_i), .req_mdata_i(req_mdata_i), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .init_done_o(init_done_o), .row_strobe_n_o(row_n),
    .lower_column_strobe_n_o(lcol_n), .upper_column_strobe_n_o(ucol_n), .write_strobe_n_o(we_n),
    .output_enable_n_o(oe_n), .mux_address_pins_o(addr), .data_pins_i(pins), .data_pins_o(dout),
    .data_pins_oe_o(doe));
  edoc_dram_model edoc_dram_model_inst (.row_n_i(row_n), .col_n_i({ucol_n, lcol_n}), .we_n_i(we_n),
    .oe_n_i(oe_n), .addr_i(addr), .ctrl_data_i(dout), .ctrl_oe_i(doe), .pins_o(pins),
    .refresh_cnt_o(refresh_cnt), .err_cnt_o(model_err));
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction
  task automatic do_req(input logic [1:0] op, input logic [17:0] a, input logic [15:0] wd, input logic [1:0] be);
    logic [15:0] md;
    logic [15:0] old;
    int k;
    md = 16'($urandom);
    old = ref_mem.exists(a) ? ref_mem[a] : 16'h0;
    @(posedge clk_i);
    #1;
    req_op_i = op;
    req_addr_i = a;
    req_wdata_i = wd;
    req_be_i = be;
    req_mdata_i = md;
    req_valid_i = 1'b1;
    k = 0;
    @(negedge clk_i);
    while (req_ready_o !== 1'b1 && k < 300) begin
      @(negedge clk_i);
      k++;
    end
    check(32'(req_ready_o), 32'h1);
    @(posedge clk_i);
    #1;
    req_valid_i = 1'b0;
    if (op == edoc_pkg::OP_READ || op == edoc_pkg::OP_RMW) begin
      k = 0;
      while (rsp_valid_o !== 1'b1 && k < 60) begin
        @(negedge clk_i);
        k++;
      end
      check(32'(rsp_valid_o), 32'h1);
      check(32'(rsp_rdata_o), 32'(old));
    end
    ref_mem[a] = op == edoc_pkg::OP_READ ? old : op == edoc_pkg::OP_RMW ? md : merge(old, wd, be);
  endtask
  task automatic results;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    n = $urandom(32'h5a7b);
    repeat (16) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    n = 0;
    while (init_done_o !== 1'b1 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    check(32'(init_done_o), 32'h1);
    t_init = cycles;
    check(32'(refresh_cnt >= 8), 32'h1);
    pool[0] = 18'h0;
    pool[1] = 18'h001ff;
    pool[7] = 18'h3ffff;
    for (int i = 2; i < 7; i++) pool[i] = 18'($urandom);
    // every address written whole first so reads always have a known value
    for (int i = 0; i < 8; i++) do_req(edoc_pkg::OP_EARLY_WRITE, pool[i], 16'($urandom), 2'h3);
    do_req(edoc_pkg::OP_LATE_WRITE, pool[0], 16'h1234, 2'h1);
    do_req(edoc_pkg::OP_EARLY_WRITE, pool[0], 16'habcd, 2'h2);
    do_req(edoc_pkg::OP_READ, pool[0], 16'h0, 2'h3);
    do_req(edoc_pkg::OP_RMW, pool[7], 16'h0, 2'h3);
    do_req(edoc_pkg::OP_READ, pool[7], 16'h0, 2'h3);
    for (int i = 0; i < 60; i++) begin
      rop = 2'($urandom);
      do_req(rop, pool[$urandom % 8], 16'($urandom),
             rop == edoc_pkg::OP_RMW ? 2'h3 : 2'($urandom_range(3, 1)));
    end
    repeat (600) @(posedge clk_i);
    check(32'(refresh_cnt - 8 >= (cycles - t_init) / REF_INT - 1), 32'h1);
    check(32'(model_err), 32'h0);
    results();
  end
endmodule
